// ===== design/shaft_monitor_pkg.sv
// Purpose: Shared constants and carriers for the shaft speed monitor
// Assumes: 125 MHz core clock, 16-bit signed sensor samples
// Notes:   Counts derive from times and frequencies below
package shaft_monitor_pkg;

  // Clock and timing figures
  localparam int CLK_HZ        = 125_000_000;
  localparam int MAX_PULSE_HZ  = 20_000;
  localparam int DIR_MAX_HZ    = 166;
  localparam int STANDSTILL_MS = 1000;
  localparam int SECS_PER_MIN  = 60;

  // Shortest accepted pulse period (rounded up)
  localparam int MIN_PERIOD_CYC =
    (CLK_HZ + MAX_PULSE_HZ - 1) / MAX_PULSE_HZ;
  // Period at the direction-freeze frequency (rounded down)
  localparam int DIR_PERIOD_CYC = CLK_HZ / DIR_MAX_HZ;
  // Time without pulses before speed reads zero
  localparam int STANDSTILL_CYC = (CLK_HZ / 1000) * STANDSTILL_MS;

  // Widths
  localparam int SAMPLE_W = 16;
  localparam int SPEED_W  = 16;
  localparam int TEETH_W  = 16;
  localparam int TIME_W   = 32;
  localparam int DIV_W    = 48;
  localparam int NUM_CH   = 3;

  // Scale factors for the two divisions
  localparam longint RPM_SCALE = longint'(CLK_HZ) * SECS_PER_MIN;
  localparam logic [DIV_W-1:0] RPM_NUMER = DIV_W'(RPM_SCALE);
  localparam logic [DIV_W-1:0] CLK_NUMER = DIV_W'(CLK_HZ);
  localparam logic [SPEED_W-1:0] SPEED_MAX = 16'hffff;

  // Static configuration
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] upper_switch_threshold;
    logic signed [SAMPLE_W-1:0] lower_switch_threshold;
    logic [TEETH_W-1:0]         wheel_tooth_count;
    logic                       normal_direction_select;
    logic                       variable_reluctance_pickup;
    logic                       gear_wheel_mode;
    logic [SPEED_W-1:0]         accel_limit;
    logic [1:0]                 channel_index;
  } cfg_t;

  // Measurement results
  typedef struct packed {
    logic [SPEED_W-1:0] speed_rpm;
    logic [SPEED_W-1:0] accel_rpm_s;
    logic               accel_negative;
    logic               accel_over_limit;
    logic               direction_valid;
    logic               direction_normal;
    logic               direction_frozen;
  } meas_t;

endpackage

// ===== design/ratio_divider.sv
// Purpose: Unsigned restoring divider, one quotient bit per cycle
// Assumes: start only while idle; denominator nonzero
// Notes:   Quotient held in a register until the next start
`timescale 1ns/1ps
module ratio_divider (
  input  wire logic                                 core_clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 start,
  input  wire logic [shaft_monitor_pkg::DIV_W-1:0]  numer,
  input  wire logic [shaft_monitor_pkg::DIV_W-1:0]  denom,
  output logic                                      busy,
  output logic                                      done,
  output logic [shaft_monitor_pkg::DIV_W-1:0]       quotient
);
  import shaft_monitor_pkg::*;

  logic [DIV_W:0]   rem;
  logic [DIV_W-1:0] dividend;
  logic [DIV_W-1:0] divisor;
  logic [5:0]       bits_left;
  logic [DIV_W:0]   next_rem;

  // Shift in the next dividend bit
  always_comb begin
    next_rem = {rem[DIV_W-1:0], dividend[DIV_W-1]};
  end

  // Iteration
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rem       <= '0;
      dividend  <= '0;
      divisor   <= '0;
      quotient  <= '0;
      bits_left <= '0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        rem       <= '0;
        dividend  <= numer;
        divisor   <= denom;
        quotient  <= '0;
        bits_left <= 6'(DIV_W);
        busy      <= 1'b1;
      end else if (busy) begin
        dividend <= {dividend[DIV_W-2:0], 1'b0};
        if (next_rem >= {1'b0, divisor}) begin
          rem      <= next_rem - {1'b0, divisor};
          quotient <= {quotient[DIV_W-2:0], 1'b1};
        end else begin
          rem      <= next_rem;
          quotient <= {quotient[DIV_W-2:0], 1'b0};
        end
        bits_left <= bits_left - 6'd1;
        if (bits_left == 6'd1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

// ===== design/shaft_speed_direction_monitor.sv
// Purpose: Speed, acceleration and direction from a toothed wheel
// Assumes: Samples on core_clk; peer pulses and health are async pins
// Notes:   Trip output high means relay energised (healthy, no trip)
//
// Notes on behaviour
// - Hysteresis thresholds turn samples into pulses
// - One pulse per tooth passing
// - Speed rpm from tooth count and period
// - Speed saturates at 16 bits
// - Pulses faster than 20 kHz ignored
// - Direction evaluated only below 166 Hz
// - Direction frozen at 166 Hz and above
// - Direction from edge shift against partner
// - Partner is next channel, cyclic A-B-C
// - Failed partner replaced by third channel
// - Reverse rotation releases the trip outside gear mode
// - Gear mode needs all three channels healthy
// - Preferred direction setting inverts normal sense
// - No direction detection with reluctance pickup
// - Acceleration is speed change per second
// - Acceleration compared against configured limit
// - Channel unhealthy forces trip de-energised
`timescale 1ns/1ps
module shaft_speed_direction_monitor #(
  parameter int DIR_PERIOD    = shaft_monitor_pkg::DIR_PERIOD_CYC,
  parameter int STANDSTILL    = shaft_monitor_pkg::STANDSTILL_CYC
) (
  input  wire logic                                     core_clk,
  input  wire logic                                     rst_n,
  input  wire logic                                     sample_valid,
  input  wire logic signed [shaft_monitor_pkg::SAMPLE_W-1:0] sample,
  input  wire shaft_monitor_pkg::cfg_t                  cfg,
  input  wire logic [shaft_monitor_pkg::NUM_CH-1:0]     peer_pulse,
  input  wire logic [shaft_monitor_pkg::NUM_CH-1:0]     peer_ok,
  input  wire logic                                     channel_ok,
  output logic                                          pulse_out,
  output shaft_monitor_pkg::meas_t                      meas,
  output logic                                          trip_energised
);
  import shaft_monitor_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SPEED,
    ST_ACCEL
  } calc_state_t;

  // Next channel in the cyclic order
  function automatic logic [1:0] next_chan(input logic [1:0] ch);
    next_chan = (ch == 2'd2) ? 2'd0 : ch + 2'd1;
  endfunction

  // Clamp a wide result to the speed width
  function automatic logic [SPEED_W-1:0] sat16(
    input logic [DIV_W-1:0] v
  );
    sat16 = (v > DIV_W'(SPEED_MAX)) ? SPEED_MAX : v[SPEED_W-1:0];
  endfunction

  localparam logic [TIME_W-1:0] MIN_PERIOD = TIME_W'(MIN_PERIOD_CYC);
  localparam logic [TIME_W-1:0] DIR_LIMIT  = TIME_W'(DIR_PERIOD);
  localparam logic [TIME_W-1:0] STILL_LIM  = TIME_W'(STANDSTILL);

  logic                    level;
  logic                    level_prev;
  logic [TIME_W-1:0]       now_cnt;
  logic [TIME_W-1:0]       last_edge;
  logic [TIME_W-1:0]       period;
  logic                    have_edge;
  logic                    have_period;
  logic [TIME_W-1:0]       since_edge;
  logic                    own_rise;
  logic                    standstill;
  logic                    slow;
  logic [NUM_CH-1:0]       peer_meta;
  logic [NUM_CH-1:0]       peer_sync;
  logic [NUM_CH-1:0]       peer_prev;
  logic [NUM_CH-1:0]       ok_meta;
  logic [NUM_CH-1:0]       ok_sync;
  logic                    own_ok_meta;
  logic                    own_ok;
  logic [TIME_W-1:0]       peer_edge [NUM_CH];
  logic [NUM_CH-1:0]       peer_seen;
  logic [1:0]              partner;
  logic [1:0]              third;
  logic                    use_third;
  logic [1:0]              src;
  logic [TIME_W-1:0]       new_period;
  logic [TIME_W-1:0]       shift;
  logic                    dir_enable;
  logic                    fwd_raw;
  calc_state_t             state;
  logic                    div_start;
  logic [DIV_W-1:0]        div_numer;
  logic [DIV_W-1:0]        div_denom;
  logic                    div_busy;
  logic                    div_done;
  logic [DIV_W-1:0]        div_quot;
  logic [TIME_W-1:0]       calc_period;
  logic [SPEED_W-1:0]      speed_prev;
  logic [SPEED_W-1:0]      speed_new;
  logic [SPEED_W-1:0]      speed_diff;
  logic                    diff_neg;

  // Two-flop synchronisers for peer pins and own health
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      peer_meta   <= '0;
      peer_sync   <= '0;
      ok_meta     <= '0;
      ok_sync     <= '0;
      own_ok_meta <= 1'b0;
      own_ok      <= 1'b0;
    end else begin
      peer_meta   <= peer_pulse;
      peer_sync   <= peer_meta;
      ok_meta     <= peer_ok;
      ok_sync     <= ok_meta;
      own_ok_meta <= channel_ok;
      own_ok      <= own_ok_meta;
    end
  end

  // Hysteresis switching on the sampled sensor signal
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      level      <= 1'b0;
      level_prev <= 1'b0;
    end else begin
      level_prev <= level;
      if (sample_valid && sample > cfg.upper_switch_threshold) begin
        level <= 1'b1;
      end else if (sample_valid &&
                   sample < cfg.lower_switch_threshold) begin
        level <= 1'b0;
      end
    end
  end

  // Free-running time base
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      now_cnt <= '0;
    end else begin
      now_cnt <= now_cnt + 1'b1;
    end
  end

  // Qualified rising edge: one per tooth, too-fast edges dropped
  always_comb begin
    since_edge = now_cnt - last_edge;
    own_rise   = level && !level_prev &&
                 (!have_edge || since_edge >= MIN_PERIOD);
    new_period = since_edge;
    standstill = have_edge && since_edge > STILL_LIM;
    slow       = !have_period || standstill ||
                 period > DIR_LIMIT;
  end

  // Edge time latch and period
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_edge   <= '0;
      period      <= '0;
      have_edge   <= 1'b0;
      have_period <= 1'b0;
      pulse_out   <= 1'b0;
    end else begin
      pulse_out <= level;
      if (own_rise) begin
        last_edge <= now_cnt;
        have_edge <= 1'b1;
        if (have_edge && !standstill) begin
          period      <= new_period;
          have_period <= 1'b1;
        end else begin
          have_period <= 1'b0;
        end
      end else if (standstill) begin
        have_period <= 1'b0;
      end
    end
  end

  // Peer edge times
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      peer_prev <= '0;
      peer_seen <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        peer_edge[i] <= '0;
      end
    end else begin
      peer_prev <= peer_sync;
      for (int i = 0; i < NUM_CH; i++) begin
        if (peer_sync[i] && !peer_prev[i]) begin
          peer_edge[i] <= now_cnt;
          peer_seen[i] <= 1'b1;
        end
      end
    end
  end

  // Partner choice and phase decision
  always_comb begin
    partner   = next_chan(cfg.channel_index);
    third     = next_chan(partner);
    use_third = !ok_sync[partner] && ok_sync[third];
    src       = use_third ? third : partner;
    shift     = now_cnt - peer_edge[src];
    // Partner lags in the normal order; the third channel leads
    fwd_raw   = (shift >= (new_period >> 1)) ^ use_third;
    dir_enable = own_rise && have_edge && !standstill &&
                 peer_seen[src] && ok_sync[src] &&
                 shift < new_period &&
                 !cfg.variable_reluctance_pickup &&
                 (new_period > DIR_LIMIT) &&
                 (!cfg.gear_wheel_mode || (&ok_sync)) &&
                 own_ok;
  end

  // Direction result, held once the wheel runs fast
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas.direction_valid  <= 1'b0;
      meas.direction_normal <= 1'b1;
      meas.direction_frozen <= 1'b0;
    end else begin
      if (own_rise && have_edge && !standstill) begin
        meas.direction_frozen <= (new_period <= DIR_LIMIT);
      end else begin
        meas.direction_frozen <= !slow;
      end
      if (cfg.variable_reluctance_pickup) begin
        meas.direction_valid <= 1'b0;
      end else if (cfg.gear_wheel_mode && !(&ok_sync)) begin
        meas.direction_valid <= 1'b0;
      end else if (dir_enable) begin
        meas.direction_valid  <= 1'b1;
        meas.direction_normal <=
          fwd_raw ^ cfg.normal_direction_select;
      end
    end
  end

  // Trip relay drive
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_energised <= 1'b0;
    end else if (!own_ok) begin
      trip_energised <= 1'b0;
    end else begin
      trip_energised <= !(meas.direction_valid &&
                          !meas.direction_normal &&
                          !cfg.gear_wheel_mode);
    end
  end

  // Division operands per calculation step
  always_comb begin
    speed_new  = sat16(div_quot);
    diff_neg   = speed_new < speed_prev;
    speed_diff = diff_neg ? speed_prev - speed_new
                          : speed_new - speed_prev;
    div_start  = 1'b0;
    div_numer  = RPM_NUMER;
    div_denom  = DIV_W'(cfg.wheel_tooth_count) * DIV_W'(calc_period);
    case (state)
      ST_IDLE: begin
        div_start = own_rise && have_edge && !standstill &&
                    !div_busy && cfg.wheel_tooth_count != '0;
        div_denom = DIV_W'(cfg.wheel_tooth_count) *
                    DIV_W'(new_period);
      end
      ST_SPEED: begin
        div_start = div_done;
        div_numer = DIV_W'(speed_diff) * CLK_NUMER;
        div_denom = DIV_W'(calc_period);
      end
      default: begin
        div_start = 1'b0;
      end
    endcase
  end

  // Calculation sequencer: speed first, then acceleration
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      calc_period <= '0;
      speed_prev  <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (div_start) begin
            calc_period <= new_period;
            state       <= ST_SPEED;
          end else if (standstill) begin
            speed_prev <= '0;
          end
        end
        ST_SPEED: begin
          if (div_done) begin
            state <= ST_ACCEL;
          end
        end
        ST_ACCEL: begin
          if (div_done) begin
            speed_prev <= sat16(DIV_W'(meas.speed_rpm));
            state      <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Published speed and acceleration
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas.speed_rpm        <= '0;
      meas.accel_rpm_s      <= '0;
      meas.accel_negative   <= 1'b0;
      meas.accel_over_limit <= 1'b0;
    end else begin
      if (state == ST_SPEED && div_done) begin
        meas.speed_rpm      <= speed_new;
        meas.accel_negative <= diff_neg;
      end else if (state == ST_IDLE && standstill) begin
        meas.speed_rpm <= '0;
      end
      if (state == ST_ACCEL && div_done) begin
        meas.accel_rpm_s <= sat16(div_quot);
        meas.accel_over_limit <=
          sat16(div_quot) > cfg.accel_limit;
      end else if (state == ST_IDLE && standstill) begin
        meas.accel_rpm_s      <= '0;
        meas.accel_over_limit <= 1'b0;
      end
    end
  end

  ratio_divider u_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .start    (div_start),
    .numer    (div_numer),
    .denom    (div_denom),
    .busy     (div_busy),
    .done     (div_done),
    .quotient (div_quot)
  );

endmodule

// ===== verif/wheel_sensor_model.sv
// Purpose: Toothed wheel sensor and two peer channel pulse trains
// Assumes: Own tooth rises at phase 0; peers lag by shift cycles
// Notes:   Stopped wheel parks the sample and every peer pulse line low
`timescale 1ns/1ps
module wheel_sensor_model (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          run,
  input  wire logic [31:0]   period,
  input  wire logic [31:0]   shift_b,
  input  wire logic [31:0]   shift_c,
  input  wire logic          b_alive,
  output logic               sample_valid,
  output logic signed [15:0] sample,
  output logic [2:0]         peer_pulse
);
  logic [31:0] phase;
  logic [31:0] lag_b;
  logic [31:0] lag_c;

  // Tooth phase, wraps once per tooth period
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= '0;
    end else if (!run || phase >= period - 32'h1) begin
      phase <= '0;
    end else begin
      phase <= phase + 32'h1;
    end
  end

  assign lag_b = (phase + period - shift_b) % period;
  assign lag_c = (phase + period - shift_c) % period;

  // Samples with a mid-level dip and an unstrobed low value per tooth
  always_comb begin
    sample_valid = !(run && phase == period / 8);
    if (!run || phase >= period / 2 || phase == period / 8) begin
      sample = 16'shfc00;
    end else if (phase == period / 4) begin
      sample = 16'sh0000;
    end else begin
      sample = 16'sh0400;
    end
    peer_pulse[0] = run && phase < period / 2;
    peer_pulse[1] = run && b_alive && lag_b < period / 2;
    peer_pulse[2] = run && lag_c < period / 2;
  end
endmodule

// ===== verif/shaft_monitor_assertions.sv
// Purpose: Port-level temporal checks for the shaft monitor
// Assumes: One clock domain, async active-low reset
// Notes:   Bound to every monitor instance
`timescale 1ns/1ps
module shaft_monitor_checker #(
  parameter int DIR_PERIOD = shaft_monitor_pkg::DIR_PERIOD_CYC,
  parameter int STANDSTILL = shaft_monitor_pkg::STANDSTILL_CYC
) (
  input wire logic                      core_clk,
  input wire logic                      rst_n,
  input wire logic                      sample_valid,
  input wire logic signed [15:0]        sample,
  input wire shaft_monitor_pkg::cfg_t   cfg,
  input wire logic [2:0]                peer_pulse,
  input wire logic [2:0]                peer_ok,
  input wire logic                      channel_ok,
  input wire logic                      pulse_out,
  input wire shaft_monitor_pkg::meas_t  meas,
  input wire logic                      trip_energised
);
  import shaft_monitor_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic        pulse_seen;
  logic [31:0] quiet;

  // Cycles since the pulse train last rose, saturating
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_seen <= 1'b0;
      quiet      <= '0;
    end else begin
      pulse_seen <= pulse_out;
      if (pulse_out && !pulse_seen) begin
        quiet <= '0;
      end else if (quiet != 32'hffffffff) begin
        quiet <= quiet + 32'h1;
      end
    end
  end

  speed_still_a: assert property (
    quiet > STANDSTILL + 4 |-> meas.speed_rpm == '0)
    else $error("speed held after the wheel stopped");

  level_set_a: assert property (
    sample_valid && sample > cfg.upper_switch_threshold |-> ##2 pulse_out)
    else $error("pulse train missed a high sample");
  level_clear_a: assert property (
    sample_valid && sample < cfg.lower_switch_threshold |-> ##2 !pulse_out)
    else $error("pulse train missed a low sample");
  rise_cause_a: assert property (
    $rose(pulse_out) |->
      $past(sample_valid && sample > cfg.upper_switch_threshold, 2))
    else $error("pulse rose without a high sample");
  trip_safe_a: assert property (
    (!channel_ok) [*5] |-> !trip_energised)
    else $error("trip held energised while channel unhealthy");
  reverse_trip_a: assert property (
    meas.direction_valid && !meas.direction_normal && !cfg.gear_wheel_mode
      |=> !trip_energised)
    else $error("reverse rotation left trip energised");
  frozen_hold_a: assert property (
    meas.direction_frozen && $past(meas.direction_frozen)
      |-> $stable(meas.direction_normal))
    else $error("direction changed while frozen");
  reluct_off_a: assert property (
    cfg.variable_reluctance_pickup [*4] |-> !meas.direction_valid)
    else $error("direction valid with reluctance pickup");
  gear_health_a: assert property (
    (cfg.gear_wheel_mode && peer_ok != 3'h7) [*6]
      |-> !meas.direction_valid)
    else $error("gear direction valid with a channel down");
  over_limit_a: assert property (
    meas.accel_over_limit |-> meas.accel_rpm_s > cfg.accel_limit)
    else $error("over-limit flag without excess acceleration");
endmodule

bind shaft_speed_direction_monitor shaft_monitor_checker #(
  .DIR_PERIOD(DIR_PERIOD),
  .STANDSTILL(STANDSTILL)
) checker_i (
  .core_clk      (core_clk),
  .rst_n         (rst_n),
  .sample_valid  (sample_valid),
  .sample        (sample),
  .cfg           (cfg),
  .peer_pulse    (peer_pulse),
  .peer_ok       (peer_ok),
  .channel_ok    (channel_ok),
  .pulse_out     (pulse_out),
  .meas          (meas),
  .trip_energised(trip_energised)
);

// ===== verif/test_shaft_speed_direction_monitor.sv
// Purpose: Self-checking bench for the shaft speed direction monitor
// Assumes: Own channel A, 625 teeth, wheel model drives all pulses
// Notes:   Shortened freeze and standstill counts keep the run brief
`timescale 1ns/1ps
module test_shaft_speed_direction_monitor;
  import shaft_monitor_pkg::*;
  localparam int DIR_P = 7000;
  localparam int STILL = 8000;
  localparam int LIMIT = 100000;
  logic               core_clk = 1'b0;
  logic               rst_n;
  logic               sample_valid;
  logic signed [15:0] sample;
  cfg_t               cfg;
  logic [2:0]         peer_pulse;
  logic [2:0]         peer_ok;
  logic               channel_ok;
  logic               pulse_out;
  meas_t              meas;
  logic               trip_energised;
  logic               run;
  logic [31:0]        period;
  logic [31:0]        shift_b;
  logic [31:0]        shift_c;
  logic               b_alive;
  int                 miscompares = 0;
  int                 checked = 0;
  int                 cycles = 0;

  shaft_speed_direction_monitor #(.DIR_PERIOD(DIR_P), .STANDSTILL(STILL)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .sample_valid(sample_valid),
    .sample(sample), .cfg(cfg), .peer_pulse(peer_pulse),
    .peer_ok(peer_ok), .channel_ok(channel_ok), .pulse_out(pulse_out),
    .meas(meas), .trip_energised(trip_energised));

  wheel_sensor_model wheel (
    .core_clk(core_clk), .rst_n(rst_n), .run(run), .period(period),
    .shift_b(shift_b), .shift_c(shift_c), .b_alive(b_alive),
    .sample_valid(sample_valid), .sample(sample), .peer_pulse(peer_pulse));

  // 125 MHz clock
  always #4 core_clk = ~core_clk;

  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Wait for own teeth, then let the calculations settle
  task automatic teeth(input int n);
    repeat (n) @(posedge pulse_out);
    repeat (150) @(posedge core_clk);
    #1;
  endtask

  task automatic conclude();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    cfg = '{upper_switch_threshold: 16'sh0100,
            lower_switch_threshold: 16'shff00,
            wheel_tooth_count: 16'h0271, normal_direction_select: 1'b0,
            variable_reluctance_pickup: 1'b0, gear_wheel_mode: 1'b0,
            accel_limit: 16'h03e8, channel_index: 2'h0};
    peer_ok = 3'h7;
    channel_ok = 1'b1;
    run = 1'b0;
    period = 32'd7500;
    shift_b = 32'd1875;
    shift_c = 32'd1875;
    b_alive = 1'b1;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    run <= 1'b1;
    teeth(3);
    check(meas.speed_rpm, 32'h0640);
    check(meas.accel_rpm_s, 32'h0000);
    check(meas.direction_valid, 1'b1);
    check(meas.direction_normal, 1'b1);
    check(meas.direction_frozen, 1'b0);
    check(trip_energised, 1'b1);
    $display("test slow_forward done");
    @(posedge core_clk);
    shift_b <= 32'd5625;
    teeth(1);
    check(meas.direction_normal, 1'b0);
    check(trip_energised, 1'b0);
    @(posedge core_clk);
    cfg.normal_direction_select <= 1'b1;
    teeth(1);
    check(meas.direction_normal, 1'b1);
    check(trip_energised, 1'b1);
    $display("test reverse done");
    @(posedge core_clk);
    peer_ok <= 3'h5;
    b_alive <= 1'b0;
    shift_c <= 32'd5625;
    teeth(1);
    check(meas.direction_valid, 1'b1);
    check(meas.direction_normal, 1'b0);
    $display("test partner_failover done");
    @(posedge core_clk);
    peer_ok <= 3'h7;
    b_alive <= 1'b1;
    cfg.normal_direction_select <= 1'b0;
    shift_b <= 32'd1875;
    teeth(1);
    @(posedge core_clk);
    period <= 32'd6400;
    shift_b <= 32'd1600;
    teeth(1);
    check(meas.speed_rpm, 32'h0753);
    check(meas.accel_rpm_s, 32'hffff);
    check(meas.accel_over_limit, 1'b1);
    check(meas.accel_negative, 1'b0);
    check(meas.direction_frozen, 1'b1);
    @(posedge core_clk);
    shift_b <= 32'd4800;
    teeth(1);
    check(meas.direction_normal, 1'b1);
    check(trip_energised, 1'b1);
    check(meas.accel_rpm_s, 32'h0000);
    check(meas.accel_over_limit, 1'b0);
    @(posedge core_clk);
    period <= 32'd7500;
    shift_b <= 32'd1875;
    teeth(1);
    check(meas.speed_rpm, 32'h0640);
    check(meas.accel_negative, 1'b1);
    check(meas.direction_frozen, 1'b0);
    $display("test fast_freeze done");
    @(posedge core_clk);
    cfg.variable_reluctance_pickup <= 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    check(meas.direction_valid, 1'b0);
    @(posedge core_clk);
    cfg.variable_reluctance_pickup <= 1'b0;
    teeth(1);
    check(meas.direction_valid, 1'b1);
    @(posedge core_clk);
    cfg.gear_wheel_mode <= 1'b1;
    peer_ok <= 3'h3;
    repeat (20) @(posedge core_clk);
    #1;
    check(meas.direction_valid, 1'b0);
    $display("test modes done");
    @(posedge core_clk);
    cfg.gear_wheel_mode <= 1'b0;
    peer_ok <= 3'h7;
    run <= 1'b0;
    repeat (STILL + 300) @(posedge core_clk);
    #1;
    check(meas.speed_rpm, 32'h0000);
    check(trip_energised, 1'b1);
    @(posedge core_clk);
    channel_ok <= 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
    check(trip_energised, 1'b0);
    $display("test standstill_health done");
    conclude();
  end
endmodule
